// ---- design/csc_pkg.sv ----
// shared constants and types of the stream recovery core
`default_nettype none
package csc_pkg;
	// ************************************************************
	// register byte offsets
	// ************************************************************
	localparam logic [5:0] OFF_CONTROL = 6'h00;
	localparam logic [5:0] OFF_STATUS = 6'h04;
	localparam logic [5:0] OFF_SIZE = 6'h08;
	localparam logic [5:0] OFF_LEVELS = 6'h0C;
	localparam logic [5:0] OFF_COEF_A = 6'h10;
	localparam logic [5:0] OFF_COEF_D = 6'h1C;
	localparam logic [5:0] OFF_OFFS_R = 6'h20;
	localparam logic [5:0] OFF_OFFS_B = 6'h28;
	// ************************************************************
	// field positions and widths
	// ************************************************************
	localparam int CTL_ENABLE = 0;
	localparam int CTL_CLIP = 1;
	localparam int SIZE_ROWS_LSB = 16;
	localparam int LEVEL_LOWER_LSB = 16;
	localparam int DIM_W = 13;
	localparam int COEF_W = 17;
	localparam int FRAC = 16;
	localparam int SUM_W = 48;
	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [31:0] RST_CONTROL = 32'h0000_0003;
	localparam logic [31:0] RST_SIZE = 32'h0438_0780;
	localparam logic [31:0] RST_LEVELS = 32'h0010_00F0;
	localparam logic [16:0] RST_COEF = 17'h0_0000;
	localparam logic [31:0] RST_OFFS = 32'h0000_0000;
	// ************************************************************
	// access timeout and answers
	// ************************************************************
	localparam int TIMEOUT_CYCLES = 128;
	localparam logic [6:0] TMO_LAST = 7'(TIMEOUT_CYCLES - 1);
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef enum logic [1:0] {WAIT_SOF, RUN, DROP_LINE} frame_state_t;
endpackage
`default_nettype wire

// ---- design/csc_stream_core.sv ----
// color-space stream core: saturation, frame recovery, register access
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`default_nettype none
// Functional notes
// - with clipping built in, overflowing or underflowing outputs saturate
// - without clipping logic, out-of-range outputs wrap in plain binary
// - outputs limited by programmable upper_clip_level and lower_clamp_level
// - both stream ports run on the single video clock
// - control port on the same single clock; only video reset and enable are synchronised
// - register transactions always complete, even with video stalled
// - video clock enable freezes video logic, not aligned to frames
// - control port clock enable gates only the register port
// - video reset clears only stream and video logic
// - control reset resets the whole core asynchronously, with no synchroniser
// - register access not done within 128 cycles answers with error
// - registers inaccessible while video reset, enable low or clock stopped
// - timed-out read or write answers with response code 10
// - status shows processing state including last frame finished
// - frame size predicts markers; early or missing markers are errors
// - early input start of frame starts output frame at once
// - late start of frame: output at programmed place, surplus dropped
// - early end_of_line_marker ends output line at once
// - late end_of_line_marker: output at programmed place, surplus dropped
// - coefficients 17-bit two's complement; luma and chroma unsigned
module csc_stream_core #(
	parameter int DW = 8,
	parameter bit HAS_CLIP = 1'b1
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic VIDEO_RESET_N,
	input wire logic VIDEO_CLOCK_ENABLE,
	input wire logic CONTROL_PORT_CLOCK_ENABLE,
	input wire logic [5:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [31:0] WRITEDATA,
	input wire logic [3:0] BYTEENABLE,
	output logic [31:0] READDATA,
	output logic WAITREQUEST,
	output logic [1:0] RESPONSE,
	input wire logic [3*DW-1:0] S_TDATA,
	input wire logic S_TVALID,
	input wire logic S_TUSER,
	input wire logic S_TLAST,
	output logic S_TREADY,
	output logic [3*DW-1:0] M_TDATA,
	output logic M_TVALID,
	output logic M_TUSER,
	output logic M_TLAST,
	input wire logic M_TREADY
);
	localparam int SW = csc_pkg::SUM_W;
	localparam int NW = csc_pkg::DIM_W;

	// ************************************************************
	// helper functions
	// ************************************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				res[8*i +: 8] = wd[8*i +: 8];
		return res;
	endfunction

	function automatic logic signed [SW-1:0] mac(input logic [DW-1:0] y, input logic [DW-1:0] c1,
		input logic signed [16:0] k1, input logic [DW-1:0] c2, input logic signed [16:0] k2,
		input logic [31:0] off);
		logic signed [SW-1:0] acc;
		acc = SW'($signed({1'b0, y})) <<< csc_pkg::FRAC;
		acc = acc + SW'(k1) * SW'($signed({1'b0, c1}));
		acc = acc + SW'(k2) * SW'($signed({1'b0, c2}));
		acc = acc + SW'($signed(off));
		return acc >>> csc_pkg::FRAC;
	endfunction

	function automatic logic [DW-1:0] limit(input logic signed [SW-1:0] v, input logic on,
		input logic [DW-1:0] hi, input logic [DW-1:0] lo);
		logic signed [SW-1:0] h;
		logic signed [SW-1:0] l;
		h = SW'($signed({1'b0, hi}));
		l = SW'($signed({1'b0, lo}));
		if (on && v > h)
			return hi;
		else if (on && v < l)
			return lo;
		else
			return v[DW-1:0];
	endfunction

	// ************************************************************
	// video reset and enable synchronisers
	// ************************************************************
	logic vrst_meta_ff;
	logic vrst_ff;
	logic ven_meta_ff;
	logic ven_ff;
	logic video_run;

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			vrst_meta_ff <= 1'b0;
			vrst_ff <= 1'b0;
			ven_meta_ff <= 1'b0;
			ven_ff <= 1'b0;
		end
		else
		begin
			vrst_meta_ff <= VIDEO_RESET_N;
			vrst_ff <= vrst_meta_ff;
			ven_meta_ff <= VIDEO_CLOCK_ENABLE;
			ven_ff <= ven_meta_ff;
		end
	end

	// video side ready only after crossing
	assign video_run = vrst_ff && ven_ff;

	// ************************************************************
	// register access
	// ************************************************************
	logic [31:0] control_ff;
	logic [31:0] size_ff;
	logic [31:0] levels_ff;
	logic [16:0] coef_ff [4];
	logic [31:0] offs_ff [3];
	logic [3:0] flag_ff;
	logic [6:0] tmo_ff;
	logic req;
	logic acc_ok;
	logic acc_to;
	logic wr_do;
	logic [5:0] coef_rel;
	logic [5:0] offs_rel;
	logic is_coef;
	logic is_offs;
	logic mapped;
	logic [31:0] status_word;
	logic [31:0] rd_mux;
	logic [3:0] flag_set;
	logic [3:0] flag_clr;
	logic [NW-1:0] cols;
	logic [NW-1:0] rows;
	logic [DW-1:0] upper;
	logic [DW-1:0] lower;
	logic clip_on;
	csc_pkg::frame_state_t state_ff;

	assign req = READ || WRITE;
	assign acc_ok = WAITREQUEST && req && video_run;
	assign acc_to = WAITREQUEST && req && !video_run && tmo_ff == csc_pkg::TMO_LAST;
	assign wr_do = CONTROL_PORT_CLOCK_ENABLE && !WAITREQUEST && WRITE && RESPONSE == csc_pkg::RESP_OK;
	assign coef_rel = ADDRESS - csc_pkg::OFF_COEF_A;
	assign offs_rel = ADDRESS - csc_pkg::OFF_OFFS_R;
	assign is_coef = ADDRESS >= csc_pkg::OFF_COEF_A && ADDRESS <= csc_pkg::OFF_COEF_D && ADDRESS[1:0] == 2'h0;
	assign is_offs = ADDRESS >= csc_pkg::OFF_OFFS_R && ADDRESS <= csc_pkg::OFF_OFFS_B && ADDRESS[1:0] == 2'h0;
	assign mapped = is_coef || is_offs || ADDRESS == csc_pkg::OFF_CONTROL || ADDRESS == csc_pkg::OFF_STATUS
		|| ADDRESS == csc_pkg::OFF_SIZE || ADDRESS == csc_pkg::OFF_LEVELS;
	// busy, last frame done and error flags
	assign status_word = {26'h0, flag_ff, state_ff == csc_pkg::WAIT_SOF && !M_TVALID,
		state_ff != csc_pkg::WAIT_SOF || M_TVALID};
	assign rd_mux = ADDRESS == csc_pkg::OFF_CONTROL ? control_ff
		: ADDRESS == csc_pkg::OFF_STATUS ? status_word
		: ADDRESS == csc_pkg::OFF_SIZE ? size_ff
		: ADDRESS == csc_pkg::OFF_LEVELS ? levels_ff
		: is_coef ? {15'h0, coef_ff[coef_rel[3:2]]}
		: is_offs ? offs_ff[offs_rel[3:2]]
		: 32'h0;
	assign flag_clr = (wr_do && BYTEENABLE[0] && ADDRESS == csc_pkg::OFF_STATUS) ? WRITEDATA[5:2] : 4'h0;

	// answer always comes, data or timeout
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			WAITREQUEST <= 1'b1;
			RESPONSE <= csc_pkg::RESP_OK;
			READDATA <= 32'h0;
			tmo_ff <= 7'h0;
		end
		else if (!WAITREQUEST)
		begin
			WAITREQUEST <= 1'b1;
			tmo_ff <= 7'h0;
		end
		else if (CONTROL_PORT_CLOCK_ENABLE && (acc_ok || acc_to))
		begin
			WAITREQUEST <= 1'b0;
			READDATA <= (acc_ok && READ) ? rd_mux : 32'h0;
			RESPONSE <= acc_to ? csc_pkg::RESP_SLVERR : (mapped ? csc_pkg::RESP_OK : csc_pkg::RESP_DECERR);
		end
		else if (CONTROL_PORT_CLOCK_ENABLE && req)
			tmo_ff <= tmo_ff + 7'h1;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			control_ff <= csc_pkg::RST_CONTROL;
			size_ff <= csc_pkg::RST_SIZE;
			levels_ff <= csc_pkg::RST_LEVELS;
			coef_ff <= '{default: csc_pkg::RST_COEF};
			offs_ff <= '{default: csc_pkg::RST_OFFS};
		end
		else if (wr_do)
		begin
			if (ADDRESS == csc_pkg::OFF_CONTROL)
				control_ff <= merge(control_ff, WRITEDATA, BYTEENABLE) & 32'h0000_0003;
			if (ADDRESS == csc_pkg::OFF_SIZE)
				size_ff <= merge(size_ff, WRITEDATA, BYTEENABLE) & 32'h1FFF_1FFF;
			if (ADDRESS == csc_pkg::OFF_LEVELS)
				levels_ff <= merge(levels_ff, WRITEDATA, BYTEENABLE);
			if (is_coef)
				coef_ff[coef_rel[3:2]] <= 17'(merge({15'h0, coef_ff[coef_rel[3:2]]}, WRITEDATA, BYTEENABLE));
			if (is_offs)
				offs_ff[offs_rel[3:2]] <= merge(offs_ff[offs_rel[3:2]], WRITEDATA, BYTEENABLE);
		end
	end

	// sticky flags, a set beats a clear
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			flag_ff <= 4'h0;
		else
			flag_ff <= (flag_ff & ~flag_clr) | flag_set;
	end

	// ************************************************************
	// conversion and saturation
	// ************************************************************
	logic [DW-1:0] in_y;
	logic [DW-1:0] in_cb;
	logic [DW-1:0] in_cr;
	logic signed [SW-1:0] r_full;
	logic signed [SW-1:0] g_full;
	logic signed [SW-1:0] b_full;

	assign cols = size_ff[NW-1:0];
	assign rows = size_ff[csc_pkg::SIZE_ROWS_LSB +: NW];
	assign upper = levels_ff[DW-1:0];
	assign lower = levels_ff[csc_pkg::LEVEL_LOWER_LSB +: DW];
	// saturate only when built in and enabled
	assign clip_on = HAS_CLIP && control_ff[csc_pkg::CTL_CLIP];
	assign in_y = S_TDATA[DW-1:0];
	assign in_cb = S_TDATA[2*DW-1:DW];
	assign in_cr = S_TDATA[3*DW-1:2*DW];
	assign r_full = mac(in_y, in_cr, coef_ff[0], in_cb, 17'sh0, offs_ff[0]);
	assign g_full = mac(in_y, in_cr, coef_ff[1], in_cb, coef_ff[2], offs_ff[1]);
	assign b_full = mac(in_y, in_cb, coef_ff[3], in_cr, 17'sh0, offs_ff[2]);

	// ************************************************************
	// frame tracking and marker recovery
	// ************************************************************
	logic [NW-1:0] col_ff;
	logic [NW-1:0] row_ff;
	logic take;
	logic drain;
	logic emit;
	logic load;
	logic [NW-1:0] pos_col;
	logic [NW-1:0] pos_row;
	logic at_line_end;
	logic at_last;
	logic out_line_end;
	csc_pkg::frame_state_t nxt_state;
	logic [NW-1:0] nxt_col;
	logic [NW-1:0] nxt_row;
	logic nxt_valid;
	logic nxt_ready;

	assign take = S_TVALID && S_TREADY && video_run;
	assign drain = M_TVALID && M_TREADY;
	assign pos_col = S_TUSER ? {NW{1'b0}} : col_ff;
	assign pos_row = S_TUSER ? {NW{1'b0}} : row_ff;
	assign at_line_end = pos_col == cols - {{NW-1{1'b0}}, 1'b1};
	assign at_last = pos_row == rows - {{NW-1{1'b0}}, 1'b1};
	assign emit = S_TUSER || state_ff == csc_pkg::RUN;
	assign load = take && emit;
	assign out_line_end = at_line_end || S_TLAST;
	assign flag_set = {take && emit && at_line_end && !S_TLAST,
		take && emit && S_TLAST && !at_line_end,
		take && !S_TUSER && state_ff == csc_pkg::WAIT_SOF,
		take && S_TUSER && state_ff != csc_pkg::WAIT_SOF};

	always_comb
	begin
		nxt_state = state_ff;
		nxt_col = col_ff;
		nxt_row = row_ff;
		if (load && out_line_end)
		begin
			nxt_col = {NW{1'b0}};
			nxt_row = pos_row + {{NW-1{1'b0}}, 1'b1};
			nxt_state = S_TLAST ? csc_pkg::RUN : csc_pkg::DROP_LINE;
			if (at_last)
			begin
				nxt_row = {NW{1'b0}};
				nxt_state = csc_pkg::WAIT_SOF;
			end
		end
		else if (load)
		begin
			nxt_col = pos_col + {{NW-1{1'b0}}, 1'b1};
			nxt_row = pos_row;
			nxt_state = csc_pkg::RUN;
		end
		else if (take && state_ff == csc_pkg::DROP_LINE && S_TLAST)
			nxt_state = csc_pkg::RUN;
		nxt_valid = (M_TVALID && !drain) || load;
		nxt_ready = !nxt_valid && (control_ff[csc_pkg::CTL_ENABLE] || nxt_state != csc_pkg::WAIT_SOF);
		// video reset clears stream side only
		if (!vrst_ff)
		begin
			nxt_state = csc_pkg::WAIT_SOF;
			nxt_col = {NW{1'b0}};
			nxt_row = {NW{1'b0}};
			nxt_valid = 1'b0;
			nxt_ready = 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state_ff <= csc_pkg::WAIT_SOF;
			col_ff <= {NW{1'b0}};
			row_ff <= {NW{1'b0}};
			M_TVALID <= 1'b0;
			S_TREADY <= 1'b0;
			M_TUSER <= 1'b0;
			M_TLAST <= 1'b0;
			M_TDATA <= {3*DW{1'b0}};
		end
		else if (ven_ff || !vrst_ff)
		begin
			state_ff <= nxt_state;
			col_ff <= nxt_col;
			row_ff <= nxt_row;
			M_TVALID <= nxt_valid;
			S_TREADY <= nxt_ready;
			if (load)
			begin
				M_TUSER <= S_TUSER;
				M_TLAST <= out_line_end;
				M_TDATA <= {limit(r_full, clip_on, upper, lower), limit(b_full, clip_on, upper, lower),
					limit(g_full, clip_on, upper, lower)};
			end
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	property p_timeout_error;
		WAITREQUEST && req && !video_run && CONTROL_PORT_CLOCK_ENABLE && tmo_ff == csc_pkg::TMO_LAST
			|=> !WAITREQUEST && RESPONSE == csc_pkg::RESP_SLVERR && READDATA == 32'h0;
	endproperty
	a_timeout_error: assert property (p_timeout_error) else $error("timeout not answered");

	property p_ok_needs_video;
		$fell(WAITREQUEST) && RESPONSE == csc_pkg::RESP_OK |-> $past(video_run);
	endproperty
	a_ok_needs_video: assert property (p_ok_needs_video) else $error("answer without video");

	property p_port_gate;
		WAITREQUEST && !CONTROL_PORT_CLOCK_ENABLE |=> WAITREQUEST && $stable(tmo_ff);
	endproperty
	a_port_gate: assert property (p_port_gate) else $error("access moved while port disabled");

	property p_video_reset;
		!vrst_ff |=> state_ff == csc_pkg::WAIT_SOF && !M_TVALID && !S_TREADY;
	endproperty
	a_video_reset: assert property (p_video_reset) else $error("stream not cleared");

	property p_video_freeze;
		vrst_ff && !ven_ff |=> $stable(state_ff) && $stable(col_ff) && $stable(M_TVALID);
	endproperty
	a_video_freeze: assert property (p_video_freeze) else $error("video state moved");

	property p_clip_range;
		load && clip_on && lower <= upper |=> M_TDATA[DW-1:0] <= $past(upper) && M_TDATA[DW-1:0] >= $past(lower);
	endproperty
	a_clip_range: assert property (p_clip_range) else $error("output outside levels");

	property p_wrap;
		load && !clip_on |=> M_TDATA[DW-1:0] == $past(g_full[DW-1:0]);
	endproperty
	a_wrap: assert property (p_wrap) else $error("output not wrapped");

	property p_sof_early;
		take && S_TUSER && state_ff == csc_pkg::RUN |=> M_TVALID && M_TUSER && flag_ff[0];
	endproperty
	a_sof_early: assert property (p_sof_early) else $error("early start lost");

	property p_sof_late;
		take && !S_TUSER && state_ff == csc_pkg::WAIT_SOF |=> !M_TVALID && state_ff == csc_pkg::WAIT_SOF;
	endproperty
	a_sof_late: assert property (p_sof_late) else $error("surplus pixel passed");

	property p_line_early;
		load && S_TLAST && !at_line_end |=> M_TLAST && col_ff == {NW{1'b0}};
	endproperty
	a_line_early: assert property (p_line_early) else $error("early line end lost");

	// late line end at programmed place
	property p_line_late;
		load && state_ff == csc_pkg::RUN && !S_TUSER && at_line_end && !S_TLAST && !at_last
			|=> M_TLAST && state_ff == csc_pkg::DROP_LINE;
	endproperty
	a_line_late: assert property (p_line_late) else $error("late line end not forced");
endmodule
`default_nettype wire

// ---- dv/csc_video_partner.sv ----
// upstream source and downstream sink model of the video stream
`default_nettype none
module csc_video_partner (
	input wire logic clk,
	input wire logic ena,
	input wire logic stall,
	output logic [23:0] s_tdata,
	output logic s_tvalid,
	output logic s_tuser,
	output logic s_tlast,
	input wire logic s_tready,
	input wire logic [23:0] m_tdata,
	input wire logic m_tvalid,
	input wire logic m_tuser,
	input wire logic m_tlast,
	output logic m_tready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [25:0] got_q[$];
	int n_stuck = 0;
	initial
	begin
		s_tdata = 24'hFFFFFF;
		s_tvalid = 1'b0;
		s_tuser = 1'b0;
		s_tlast = 1'b0;
		m_tready = 1'b1;
	end
	// ************************************************************
	// source: one beat, held until taken
	// ************************************************************
	task automatic send(input logic [23:0] d, input logic u, input logic l);
		int n;
		n = 0;
		@(posedge clk);
		s_tdata <= d;
		s_tvalid <= 1'b1;
		s_tuser <= u;
		s_tlast <= l;
		do
		begin
			@(posedge clk);
			n++;
		end
		while ((s_tready !== 1'b1 || ena !== 1'b1) && n < 200);
		if (n >= 200)
			n_stuck++;
		s_tvalid <= 1'b0;
		s_tuser <= 1'b0;
		s_tlast <= 1'b0;
		s_tdata <= ~d;
	endtask
	// ************************************************************
	// sink: records beats, stalls every other cycle while stall is set
	// ************************************************************
	// sink gated by shared enable
	always @(posedge clk)
	begin
		if (m_tvalid === 1'b1 && m_tready === 1'b1 && ena === 1'b1)
			got_q.push_back({m_tuser, m_tlast, m_tdata});
		m_tready <= stall ? ~m_tready : 1'b1;
	end
endmodule
`default_nettype wire

// ---- dv/tb_csc_stream_core.sv ----
// self-checking bench of the stream recovery core
`default_nettype none
module tb_csc_stream_core;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic VIDEO_RESET_N = 1'b1;
	logic VIDEO_CLOCK_ENABLE = 1'b1;
	logic CONTROL_PORT_CLOCK_ENABLE = 1'b1;
	logic [5:0] ADDRESS = 6'h00;
	logic READ = 1'b0;
	logic WRITE = 1'b0;
	logic [31:0] WRITEDATA = 32'h00000000;
	logic [3:0] BYTEENABLE = 4'hF;
	logic [31:0] READDATA;
	logic WAITREQUEST;
	logic [1:0] RESPONSE;
	logic [23:0] S_TDATA, M_TDATA;
	logic S_TVALID, S_TUSER, S_TLAST, S_TREADY, M_TVALID, M_TUSER, M_TLAST, M_TREADY;
	logic stall = 1'b0;
	logic clip_on = 1'b1;
	int n_mismatch = 0;
	int num_checks = 0;
	int wait_n;
	logic [25:0] exp_q[$];
	logic [7:0] ytab[4] = '{8'h05, 8'h40, 8'h80, 8'hFF};
	always #20 CLK = ~CLK;
	csc_stream_core #(.DW(8), .HAS_CLIP(1'b1)) i_dut (.CLK(CLK), .RST_N(RST_N), .VIDEO_RESET_N(VIDEO_RESET_N),
		.VIDEO_CLOCK_ENABLE(VIDEO_CLOCK_ENABLE), .CONTROL_PORT_CLOCK_ENABLE(CONTROL_PORT_CLOCK_ENABLE),
		.ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE),
		.READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .RESPONSE(RESPONSE), .S_TDATA(S_TDATA),
		.S_TVALID(S_TVALID), .S_TUSER(S_TUSER), .S_TLAST(S_TLAST), .S_TREADY(S_TREADY), .M_TDATA(M_TDATA),
		.M_TVALID(M_TVALID), .M_TUSER(M_TUSER), .M_TLAST(M_TLAST), .M_TREADY(M_TREADY));
	csc_video_partner i_far (.clk(CLK), .ena(VIDEO_CLOCK_ENABLE), .stall(stall), .s_tdata(S_TDATA),
		.s_tvalid(S_TVALID), .s_tuser(S_TUSER), .s_tlast(S_TLAST), .s_tready(S_TREADY), .m_tdata(M_TDATA),
		.m_tvalid(M_TVALID), .m_tuser(M_TUSER), .m_tlast(M_TLAST), .m_tready(M_TREADY));
	// ************************************************************
	// helpers
	// ************************************************************
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] rd, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge CLK);
		ADDRESS <= a;
		WRITEDATA <= d;
		BYTEENABLE <= be;
		WRITE <= wr;
		READ <= ~wr;
		do
		begin
			@(posedge CLK);
			n++;
		end
		while (WAITREQUEST !== 1'b0 && n < 400);
		rd = READDATA;
		rs = RESPONSE;
		wait_n = n;
		READ <= 1'b0;
		WRITE <= 1'b0;
		chk(32'(n < 400), 32'h1);
	endtask
	task automatic rreg(input logic [5:0] a, input logic [31:0] e, input logic [1:0] r);
		logic [31:0] d;
		logic [1:0] s;
		bus(1'b0, a, 32'h00000000, 4'hF, d, s);
		chk(d, e);
		chk(32'(s), 32'(r));
	endtask
	task automatic wreg(input logic [5:0] a, input logic [31:0] v, input logic [3:0] be, input logic [1:0] r);
		logic [31:0] d;
		logic [1:0] s;
		bus(1'b1, a, v, be, d, s);
		chk(32'(s), 32'(r));
	endtask
	task automatic stat(input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] s;
		bus(1'b0, csc_pkg::OFF_STATUS, 32'h00000000, 4'hF, d, s);
		chk(d & 32'h0000003F, e | 32'h00000002);
		wreg(csc_pkg::OFF_STATUS, 32'h0000003C, 4'h1, csc_pkg::RESP_OK);
	endtask
	function automatic logic [7:0] ev(input logic [7:0] y, input int o);
		int s;
		s = int'(y) - o;
		if (clip_on && s > 32'sh80)
			s = 32'sh80;
		if (clip_on && s < 32'sh20)
			s = 32'sh20;
		return s[7:0];
	endfunction
	task automatic px(input logic [7:0] y, input logic u, l, e, eu, el);
		i_far.send({8'h3C, 8'hA5, y}, u, l);
		if (e)
			exp_q.push_back({eu, el, ev(y, 16), ev(y, 0), ev(y, 8)});
	endtask
	task automatic row(input logic f);
		for (int i = 0; i < 4; i++)
			px(ytab[i], f && i == 0, i == 3, 1'b1, f && i == 0, i == 3);
	endtask
	task automatic cmp_stream();
		int n;
		n = 0;
		while (i_far.got_q.size() < exp_q.size() && n < 2000)
		begin
			@(posedge CLK);
			n++;
		end
		repeat (4) @(posedge CLK);
		chk(32'(i_far.n_stuck), 32'h0);
		chk(32'(i_far.got_q.size()), 32'(exp_q.size()));
		while (exp_q.size() > 0 && i_far.got_q.size() > 0)
			chk(32'(i_far.got_q.pop_front()), 32'(exp_q.pop_front()));
		exp_q.delete();
		i_far.got_q.delete();
	endtask
	// ************************************************************
	// test sequence
	// ************************************************************
	initial
	begin
		repeat (6) @(posedge CLK);
		RST_N <= 1'b1;
		rreg(csc_pkg::OFF_CONTROL, csc_pkg::RST_CONTROL, csc_pkg::RESP_OK);
		rreg(csc_pkg::OFF_SIZE, csc_pkg::RST_SIZE, csc_pkg::RESP_OK);
		rreg(csc_pkg::OFF_LEVELS, csc_pkg::RST_LEVELS, csc_pkg::RESP_OK);
		rreg(csc_pkg::OFF_COEF_A, 32'h00000000, csc_pkg::RESP_OK);
		wreg(csc_pkg::OFF_COEF_A, 32'hFFFFFFFF, 4'hF, csc_pkg::RESP_OK);
		rreg(csc_pkg::OFF_COEF_A, 32'h0001FFFF, csc_pkg::RESP_OK);
		wreg(csc_pkg::OFF_COEF_A, 32'h00000000, 4'hF, csc_pkg::RESP_OK);
		rreg(6'h3C, 32'h00000000, csc_pkg::RESP_DECERR);
		wreg(csc_pkg::OFF_CONTROL, 32'h00000000, 4'hF, csc_pkg::RESP_OK);
		wreg(csc_pkg::OFF_SIZE, 32'h00020004, 4'hF, csc_pkg::RESP_OK);
		wreg(csc_pkg::OFF_LEVELS, 32'h00200080, 4'hF, csc_pkg::RESP_OK);
		wreg(csc_pkg::OFF_OFFS_R, 32'hFFF00000, 4'hF, csc_pkg::RESP_OK);
		wreg(6'h24, 32'hFFF80000, 4'hF, csc_pkg::RESP_OK);
		wreg(csc_pkg::OFF_CONTROL, 32'h00000003, 4'hF, csc_pkg::RESP_OK);
		// clipped frame into a stalling sink
		stall <= 1'b1;
		row(1'b1);
		row(1'b0);
		cmp_stream();
		stall <= 1'b0;
		stat(32'h00000000);
		// short first line
		px(8'h05, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
		px(8'h40, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
		row(1'b0);
		cmp_stream();
		stat(32'h00000010);
		// long first line, surplus dropped
		for (int i = 0; i < 4; i++)
			px(ytab[i], i == 0, 1'b0, 1'b1, i == 0, i == 3);
		px(8'h80, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		row(1'b0);
		cmp_stream();
		stat(32'h00000020);
		// frame cut by a new start
		px(8'h05, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
		px(8'h40, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		row(1'b1);
		row(1'b0);
		cmp_stream();
		stat(32'h00000004);
		// surplus beat after last row
		row(1'b1);
		row(1'b0);
		px(8'h40, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		row(1'b1);
		row(1'b0);
		cmp_stream();
		stat(32'h00000008);
		// clipping off, register port disabled
		wreg(csc_pkg::OFF_CONTROL, 32'h00000001, 4'hF, csc_pkg::RESP_OK);
		clip_on = 1'b0;
		CONTROL_PORT_CLOCK_ENABLE <= 1'b0;
		row(1'b1);
		row(1'b0);
		cmp_stream();
		CONTROL_PORT_CLOCK_ENABLE <= 1'b1;
		wreg(csc_pkg::OFF_CONTROL, 32'h00000003, 4'hF, csc_pkg::RESP_OK);
		clip_on = 1'b1;
		// video enable low: accesses time out
		VIDEO_CLOCK_ENABLE <= 1'b0;
		repeat (4) @(posedge CLK);
		rreg(csc_pkg::OFF_SIZE, 32'h00000000, csc_pkg::RESP_SLVERR);
		chk(32'(wait_n >= 128 && wait_n <= 135), 32'h1);
		wreg(csc_pkg::OFF_SIZE, 32'h00050005, 4'hF, csc_pkg::RESP_SLVERR);
		VIDEO_CLOCK_ENABLE <= 1'b1;
		repeat (4) @(posedge CLK);
		rreg(csc_pkg::OFF_SIZE, 32'h00020004, csc_pkg::RESP_OK);
		// video reset held beyond 32 cycles
		VIDEO_RESET_N <= 1'b0;
		repeat (8) @(posedge CLK);
		rreg(csc_pkg::OFF_CONTROL, 32'h00000000, csc_pkg::RESP_SLVERR);
		VIDEO_RESET_N <= 1'b1;
		repeat (4) @(posedge CLK);
		rreg(csc_pkg::OFF_SIZE, 32'h00020004, csc_pkg::RESP_OK);
		row(1'b1);
		row(1'b0);
		cmp_stream();
		// whole-core reset mid-run
		RST_N <= 1'b0;
		repeat (2) @(posedge CLK);
		chk(32'(M_TVALID), 32'h0);
		RST_N <= 1'b1;
		rreg(csc_pkg::OFF_SIZE, csc_pkg::RST_SIZE, csc_pkg::RESP_OK);
		finish_test();
	end
	initial
	begin
		#(40 * 20000);
		n_mismatch++;
		finish_test();
	end
endmodule
`default_nettype wire
